// ---- hdl/ext_bus_master.sv ----
// asynchronous external bus master with dynamic bus sizing
// assumes a core-side request port on the same clock and raw external pins
`timescale 1ns/1ps
`default_nettype none

module ext_bus_master
  import ext_bus_pkg::*;
(
  input  wire logic              clk_sys_i,
  input  wire logic              reset_n_i,
  // core-side request
  input  wire logic              req_valid_i,
  output logic                   req_ready_o,
  input  wire logic              req_write_i,
  input  wire logic [ADDR_W-1:0] req_addr_i,
  input  wire logic [1:0]        req_len_i,
  input  wire logic [2:0]        req_space_i,
  input  wire logic              req_iack_i,
  input  wire logic [OPND_W-1:0] req_wdata_i,
  // core-side response
  output logic                   rsp_valid_o,
  input  wire logic              rsp_ready_i,
  output logic [OPND_W-1:0]      rsp_data_o,
  output logic                   rsp_fault_o,
  output logic                   rsp_autovec_o,
  // external bus pins
  output logic [ADDR_W-1:0]      addr_o,
  output logic                   ctrl_oe_o,
  output logic [DATA_W-1:0]      data_o,
  output logic                   data_oe_o,
  input  wire logic [DATA_W-1:0] data_i,
  output logic                   address_strobe_n_o,
  output logic                   data_strobe_n_o,
  output logic                   read_write_o,
  output logic [1:0]             transfer_length_code_o,
  output logic [2:0]             space_code_o,
  input  wire logic [1:0]        port_width_ack_n_i,
  input  wire logic              bus_fault_n_i,
  output logic                   bus_fault_n_o,
  output logic                   bus_fault_oe_o,
  input  wire logic              halt_n_i,
  input  wire logic              auto_vector_ack_n_i,
  input  wire logic              ext_master_owns_i,
  // status toward the core
  output logic                   halted_o,
  output logic                   irq_hold_o
);

  // reset release synchroniser
  logic rst_meta_r;  // first stage, read only by the second
  logic rst_n_r;     // reset copy used everywhere
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rst_meta_r <= 1'b0;
      rst_n_r    <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_n_r    <= rst_meta_r;
    end
  end

  // pin synchronisers; data lags by the same two cycles as the acknowledge
  localparam int SYNC_W = DATA_W + 6;
  logic [SYNC_W-1:0] pin_meta_r;  // first stage
  logic [SYNC_W-1:0] pin_sync_r;  // second stage
  always_ff @(posedge clk_sys_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      pin_meta_r <= {SYNC_W{1'b1}};
      pin_sync_r <= {SYNC_W{1'b1}};
    end else begin
      pin_meta_r <= {data_i, port_width_ack_n_i, bus_fault_n_i, halt_n_i,
                     auto_vector_ack_n_i, ext_master_owns_i};
      pin_sync_r <= pin_meta_r;
    end
  end

  logic [DATA_W-1:0] din_s;   // synchronised data lines
  logic [1:0]        ack_s;   // synchronised acknowledge pair
  logic              fault_s; // bus fault asserted
  logic              halt_s;  // halt asserted
  logic              auto_vector_ack_n_s;  // autovector asserted
  logic              owned_s; // another master holds the bus
  assign din_s   = pin_sync_r[SYNC_W-1:6];
  assign ack_s   = pin_sync_r[5:4];
  assign fault_s = !pin_sync_r[3];
  assign halt_s  = !pin_sync_r[2];
  assign auto_vector_ack_n_s  = !pin_sync_r[1];
  assign owned_s = pin_sync_r[0];

  // cycle state and operand bookkeeping
  bus_state_type     state_r;     // sequencer
  logic [ADDR_W-1:0] addr_r;      // current byte address
  logic [2:0]        rem_r;       // bytes still to move, 0..4
  logic [OPND_W-1:0] wsh_r;       // write operand, left aligned
  logic [OPND_W-1:0] acc_r;       // read assembly
  logic [2:0]        space_r;     // space code
  logic              rw_r;        // 1 read, 0 write
  logic              iack_r;      // interrupt acknowledge cycle
  logic              retry_r;     // faulted cycle to rerun
  logic              finish_r;    // operand done in this close
  logic              rsp_fault_r; // outcome flags for the response
  logic              rsp_auto_vector_ack_n_r;
  logic [MON_W-1:0]  mon_cnt_r;   // bus monitor counter
  logic              mon_drv_r;   // monitor pulling bus fault low

  // termination decode, only meaningful while waiting
  logic ack8;      // 8-bit port done
  logic ack16;     // 16-bit port done
  logic auto_vector_ack_n_hit;  // autovector on an interrupt acknowledge
  logic mon_to;    // monitor timeout
  logic fault_hit; // cycle ends in fault
  logic term;      // any termination
  logic two_b;     // two bytes move this cycle
  logic [2:0] nbytes;
  logic [OPND_W-1:0] rd_merge;
  assign ack8      = ack_s == ACK_PORT8;
  assign ack16     = ack_s == ACK_PORT16;
  assign auto_vector_ack_n_hit  = iack_r && space_r == SPC_PROCESSOR && auto_vector_ack_n_s;
  assign mon_to    = mon_cnt_r == MON_W'(BUS_MON_CYC);
  assign fault_hit = fault_s || mon_to;
  assign term      = (state_r == ST_WAIT) && (ack8 || ack16 || auto_vector_ack_n_hit || fault_hit);
  assign two_b     = ack16 && !addr_r[0] && rem_r >= 3'd2;
  assign nbytes    = two_b ? 3'd2 : 3'd1;

  // read bytes of this cycle merged under the earlier ones; 8-bit on upper lane
  always_comb begin
    if (two_b) begin
      rd_merge = {acc_r[OPND_W-17:0], din_s};
    end else if (ack16 && addr_r[0]) begin
      rd_merge = {acc_r[OPND_W-9:0], din_s[7:0]};
    end else begin
      rd_merge = {acc_r[OPND_W-9:0], din_s[15:8]};
    end
  end

  // response buffer handshake
  logic       buf_push;
  logic [1:0] buf_cnt_r;
  assign req_ready_o = (state_r == ST_IDLE) && !owned_s && !halt_s && buf_cnt_r != 2'd2;

  // sequencer
  bus_state_type state_nxt;
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE:   if (req_valid_i && req_ready_o) state_nxt = ST_ADDR;
      ST_ADDR:   state_nxt = ST_STROBE;
      ST_STROBE: state_nxt = ST_DATA;
      ST_DATA:   state_nxt = ST_WAIT;
      ST_WAIT:   if (term) state_nxt = ST_CLOSE;
      ST_CLOSE: begin
        if (halt_s || retry_r) state_nxt = ST_HALT;
        else if (owned_s) state_nxt = ST_CLOSE;
        else if (finish_r) state_nxt = ST_IDLE;
        else state_nxt = ST_ADDR;
      end
      ST_HALT: begin
        if (!halt_s && !owned_s) state_nxt = finish_r ? ST_IDLE : ST_ADDR;
      end
      default:   state_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_r) begin
    if (!rst_n_r) state_r <= ST_IDLE;
    else          state_r <= state_nxt;
  end

  // pin copies move only as a bus cycle starts, so a halt parks them on the
  // cycle just finished while, after a good acknowledge, the internal pointer has already advanced
  logic [ADDR_W-1:0] addr_pin_r;  // address shown on the pins
  logic [1:0]        len_pin_r;   // length code shown on the pins
  always_ff @(posedge clk_sys_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      addr_pin_r <= ADDR_RST;
      len_pin_r  <= LEN_BYTE;
    end else if (state_nxt == ST_ADDR) begin
      addr_pin_r <= (state_r == ST_IDLE) ? req_addr_i : addr_r;
      len_pin_r  <= (state_r == ST_IDLE) ? req_len_i : rem_r[1:0];
    end
  end

  // operand setup and per-cycle advance
  always_ff @(posedge clk_sys_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      addr_r  <= ADDR_RST;
      rem_r   <= 3'd1;
      wsh_r   <= OPND_RST;
      acc_r   <= OPND_RST;
      space_r <= SPC_RST;
      rw_r    <= 1'b1;
      iack_r  <= 1'b0;
    end else if (state_r == ST_IDLE && req_valid_i && req_ready_o) begin
      addr_r  <= req_addr_i;
      rem_r   <= (req_len_i == LEN_LONG) ? 3'd4 : {1'b0, req_len_i};
      // left align so the next byte to go is always on top
      case (req_len_i)
        LEN_BYTE: wsh_r <= {req_wdata_i[7:0], 24'h00_0000};
        LEN_WORD: wsh_r <= {req_wdata_i[15:0], 16'h0000};
        LEN_THREE: wsh_r <= {req_wdata_i[23:0], 8'h00};
        default:  wsh_r <= req_wdata_i;
      endcase
      acc_r   <= OPND_RST;
      space_r <= req_space_i;
      rw_r    <= !req_write_i;
      iack_r  <= req_iack_i;
    end else if (term && !fault_hit && !auto_vector_ack_n_hit) begin
      // advance only on a good acknowledge; faults keep the cycle's codes
      addr_r <= addr_r + ADDR_W'(nbytes);
      rem_r  <= rem_r - nbytes;
      wsh_r  <= two_b ? {wsh_r[15:0], 16'h0000} : {wsh_r[23:0], 8'h00};
      if (rw_r) acc_r <= rd_merge;
    end
  end

  // termination outcome: retry, finish, flags
  always_ff @(posedge clk_sys_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      retry_r     <= 1'b0;
      finish_r    <= 1'b0;
      rsp_fault_r <= 1'b0;
      rsp_auto_vector_ack_n_r  <= 1'b0;
    end else if (state_r == ST_IDLE) begin
      retry_r     <= 1'b0;
      finish_r    <= 1'b0;
      rsp_fault_r <= 1'b0;
      rsp_auto_vector_ack_n_r  <= 1'b0;
    end else if (term) begin
      retry_r     <= fault_hit && halt_s;
      finish_r    <= fault_hit ? !halt_s : (auto_vector_ack_n_hit || rem_r == nbytes);
      rsp_fault_r <= fault_hit && !halt_s;
      rsp_auto_vector_ack_n_r  <= auto_vector_ack_n_hit && !fault_hit;
    end else if (state_r == ST_ADDR) begin
      retry_r <= 1'b0;
    end
  end

  // bus monitor; its bus fault drive is held off while another master owns the bus
  always_ff @(posedge clk_sys_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      mon_cnt_r <= '0;
      mon_drv_r <= 1'b0;
    end else begin
      mon_drv_r <= mon_to && state_r == ST_WAIT && !owned_s;
      if (state_r == ST_WAIT && !term) mon_cnt_r <= mon_cnt_r + 1'b1;
      else mon_cnt_r <= '0;
    end
  end
  assign bus_fault_n_o  = 1'b0;
  assign bus_fault_oe_o = mon_drv_r;   // open drain; a foreign master brings its own

  // write data register, all sixteen lines
  logic [DATA_W-1:0] dout_r;
  always_ff @(posedge clk_sys_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      dout_r <= DOUT_RST;
    end else if (state_r == ST_STROBE) begin
      // odd address or single byte copies the byte onto both lanes
      if (addr_r[0] || rem_r == 3'd1) dout_r <= {wsh_r[31:24], wsh_r[31:24]};
      else                            dout_r <= wsh_r[31:16];
    end
  end

  // pin drive
  logic cyc_live; // a strobe window is open
  assign cyc_live               = state_r == ST_STROBE || state_r == ST_DATA
                                || state_r == ST_WAIT;
  assign addr_o                 = addr_pin_r;
  assign ctrl_oe_o              = !owned_s;
  assign transfer_length_code_o = len_pin_r;
  assign space_code_o           = space_r;
  assign read_write_o           = rw_r;
  assign address_strobe_n_o     = !cyc_live;
  assign data_strobe_n_o        = !(rw_r ? cyc_live : state_r == ST_WAIT);
  assign data_o                 = dout_r;
  assign data_oe_o              = !rw_r && (state_r == ST_DATA || state_r == ST_WAIT);
  assign halted_o               = state_r == ST_HALT;
  assign irq_hold_o             = state_r == ST_HALT;

  // two-entry response buffer; a stalled consumer only blocks new requests
  logic [RSP_W-1:0] buf_mem_r [2];
  logic             buf_wp_r;
  logic             buf_rp_r;
  logic             buf_pop;
  assign buf_push    = state_r == ST_CLOSE && finish_r && !halt_s && !retry_r
                     && !owned_s
                     || state_r == ST_HALT && finish_r && state_nxt == ST_IDLE;
  assign buf_pop     = rsp_valid_o && rsp_ready_i;
  assign rsp_valid_o = buf_cnt_r != 2'd0;

  always_ff @(posedge clk_sys_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      buf_wp_r  <= 1'b0;
      buf_rp_r  <= 1'b0;
      buf_cnt_r <= 2'd0;
    end else begin
      if (buf_push) buf_wp_r <= !buf_wp_r;
      if (buf_pop)  buf_rp_r <= !buf_rp_r;
      buf_cnt_r <= buf_cnt_r + {1'b0, buf_push} - {1'b0, buf_pop};
    end
  end

  // entry storage, one slot per generate pass
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_slot
      always_ff @(posedge clk_sys_i or negedge rst_n_r) begin
        if (!rst_n_r) buf_mem_r[gi] <= '0;
        else if (buf_push && buf_wp_r == 1'(gi))
          buf_mem_r[gi] <= {rsp_fault_r, rsp_auto_vector_ack_n_r, acc_r};
      end
    end
  endgenerate
  assign rsp_data_o    = buf_mem_r[buf_rp_r][OPND_W-1:0];
  assign rsp_fault_o   = buf_mem_r[buf_rp_r][RSP_FAULT];
  assign rsp_autovec_o = buf_mem_r[buf_rp_r][RSP_AUTO_VECTOR_ACK_N];

  // checks
  a_as_after_addr: assert property (@(posedge clk_sys_i) disable iff (!rst_n_r)
    state_r == ST_ADDR |=> !address_strobe_n_o && $stable(addr_o))
    else $error("address strobe not one half clock after start");
  a_read_ds_with_as: assert property (@(posedge clk_sys_i) disable iff (!rst_n_r)
    $fell(address_strobe_n_o) && rw_r |-> !data_strobe_n_o)
    else $error("read data strobe late");
  a_write_ds_delay: assert property (@(posedge clk_sys_i) disable iff (!rst_n_r)
    $fell(address_strobe_n_o) && !rw_r |-> data_strobe_n_o ##1 data_strobe_n_o && data_oe_o
    ##1 !data_strobe_n_o)
    else $error("write data strobe not one clock after address strobe");
  a_addr_held: assert property (@(posedge clk_sys_i) disable iff (!rst_n_r)
    !address_strobe_n_o && $past(!address_strobe_n_o) |-> $stable(addr_o)
    && $stable(space_code_o) && $stable(transfer_length_code_o))
    else $error("address moved under strobe");
  a_rw_stable: assert property (@(posedge clk_sys_i) disable iff (!rst_n_r)
    $changed(read_write_o) |-> $past(state_r) == ST_IDLE)
    else $error("direction changed mid operand");
  a_halt_float: assert property (@(posedge clk_sys_i) disable iff (!rst_n_r)
    state_r == ST_HALT |-> !data_oe_o && address_strobe_n_o && data_strobe_n_o
    && irq_hold_o)
    else $error("bus not quiet while halted");
  a_close_strobes: assert property (@(posedge clk_sys_i) disable iff (!rst_n_r)
    term |=> address_strobe_n_o && data_strobe_n_o ##1 address_strobe_n_o)
    else $error("strobes not negated after termination");
  a_fault_retry: assert property (@(posedge clk_sys_i) disable iff (!rst_n_r)
    term && fault_s && halt_s |=> ##1 state_r == ST_HALT && $stable(addr_o))
    else $error("faulted cycle under halt not parked for retry");
  a_auto_vector_ack_n_only_iack: assert property (@(posedge clk_sys_i) disable iff (!rst_n_r)
    buf_push && rsp_auto_vector_ack_n_r |-> iack_r && space_r == SPC_PROCESSOR)
    else $error("autovector outside interrupt acknowledge");
  a_monitor_fault: assert property (@(posedge clk_sys_i) disable iff (!rst_n_r)
    state_r == ST_WAIT && mon_to && !owned_s |=> bus_fault_oe_o)
    else $error("monitor did not raise bus fault");
  a_ack_narrow: assert property (@(posedge clk_sys_i) disable iff (!rst_n_r)
    term && ack8 && !fault_hit && !auto_vector_ack_n_hit |=> rem_r == $past(rem_r) - 3'd1)
    else $error("8-bit port moved more than one byte");

  c_read16: cover property (@(posedge clk_sys_i) disable iff (!rst_n_r)
    term && ack16 && rw_r);
  c_write8: cover property (@(posedge clk_sys_i) disable iff (!rst_n_r)
    term && ack8 && !rw_r);
  c_retry: cover property (@(posedge clk_sys_i) disable iff (!rst_n_r)
    term && fault_s && halt_s);
  c_buf_full: cover property (@(posedge clk_sys_i) disable iff (!rst_n_r)
    buf_cnt_r == 2'd2);

endmodule

`default_nettype wire

// ---- hdl/ext_bus_pkg.sv ----
// constants shared by the external bus master: pin codes, timing, layouts
// assumes a single 200 MHz system clock; one sys cycle is half a bus clock
package ext_bus_pkg;

  // system clock period and bus monitor limit
  localparam int CLK_PERIOD_NS  = 5;
  localparam int BUS_MON_NS     = 1280;                        // no-ack timeout
  localparam int BUS_MON_CYC    = BUS_MON_NS / CLK_PERIOD_NS;  // rounds down
  localparam int MON_W          = 9;

  // pin and operand widths
  localparam int ADDR_W         = 24;
  localparam int DATA_W         = 16;
  localparam int OPND_W         = 32;

  // transfer length codes, bytes still to move
  localparam logic [1:0] LEN_BYTE  = 2'h1;
  localparam logic [1:0] LEN_WORD  = 2'h2;
  localparam logic [1:0] LEN_THREE = 2'h3;
  localparam logic [1:0] LEN_LONG  = 2'h0;

  // address space codes
  localparam logic [2:0] SPC_USER_DATA = 3'h1;
  localparam logic [2:0] SPC_USER_PROG = 3'h2;
  localparam logic [2:0] SPC_SUPV_DATA = 3'h5;
  localparam logic [2:0] SPC_SUPV_PROG = 3'h6;
  localparam logic [2:0] SPC_PROCESSOR = 3'h7;

  // acknowledge pair decode, active low pins
  localparam logic [1:0] ACK_WAIT  = 2'h3;
  localparam logic [1:0] ACK_PORT8 = 2'h2;
  localparam logic [1:0] ACK_PORT16 = 2'h1;

  // values after reset
  localparam logic [ADDR_W-1:0] ADDR_RST = 24'h00_0000;
  localparam logic [2:0]        SPC_RST  = 3'h0;
  localparam logic [DATA_W-1:0] DOUT_RST = 16'h0000;
  localparam logic [OPND_W-1:0] OPND_RST = 32'h0000_0000;

  // response buffer entry: fault, autovector, data
  localparam int RSP_W     = OPND_W + 2;
  localparam int RSP_FAULT = OPND_W + 1;
  localparam int RSP_AUTO_VECTOR_ACK_N  = OPND_W;

  // bus cycle sequencer, one-hot
  typedef enum logic [6:0] {
    ST_IDLE   = 7'h01,  // no cycle
    ST_ADDR   = 7'h02,  // address and codes driven, strobes high
    ST_STROBE = 7'h04,  // address strobe low
    ST_DATA   = 7'h08,  // write data driven
    ST_WAIT   = 7'h10,  // both strobes low, waiting for termination
    ST_CLOSE  = 7'h20,  // strobes negated
    ST_HALT   = 7'h40   // parked by halt, data lines floated, strobes high
  } bus_state_type;

endpackage

// ---- verification/bus_partner_model.sv ----
// memory or peripheral sitting on the asynchronous bus, byte store of 256 entries
// assumes raw master pins; the bench resolves shared data and fault wires
`timescale 1ns/1ps
`default_nettype none
module bus_partner_model
  import ext_bus_pkg::*;
(
  input  wire logic              clk_i,
  input  wire logic              as_n_i,
  input  wire logic              ds_n_i,
  input  wire logic              rw_i,
  input  wire logic [ADDR_W-1:0] addr_i,
  input  wire logic [1:0]        len_i,
  input  wire logic [DATA_W-1:0] wdata_i,
  input  wire logic              port16_i,
  input  wire logic [1:0]        wait_i,    // wait states before answering
  input  wire logic [1:0]        mode_i,    // 0 ack, 1 fault, 2 mute, 3 vector
  output logic      [DATA_W-1:0] data_o,
  output logic      [1:0]        ack_n_o,
  output logic                   fault_n_o,
  output logic                   auto_vector_ack_n_n_o
);
  logic [7:0]        mem [256];  // byte store
  logic [1:0]        cnt_r;      // wait states spent
  logic [DATA_W-1:0] junk_r;     // released lines wander, never hold old data
  logic [7:0]        a;          // low address bits only
  assign a = addr_i[7:0];
  // memory bytes only while selected for a read, junk otherwise; byte port leaves lower lane junk
  assign data_o = (!as_n_i && !ds_n_i && rw_i) ? (port16_i ? {mem[{a[7:1], 1'b0}],
    mem[{a[7:1], 1'b1}]} : {mem[a], junk_r[7:0]}) : junk_r;
  initial begin
    {ack_n_o, fault_n_o, auto_vector_ack_n_n_o, cnt_r, junk_r} = 22'h3c_c5a5;
  end
  // answer after the wait states, hold until the address strobe goes away
  always @(posedge clk_i) begin
    junk_r <= junk_r + 16'h3c5b;
    if (as_n_i) begin
      {ack_n_o, fault_n_o, auto_vector_ack_n_n_o, cnt_r} <= 6'h3c;
    end else if (!ds_n_i && &ack_n_o && fault_n_o && auto_vector_ack_n_n_o) begin
      if (cnt_r != wait_i) begin
        cnt_r <= cnt_r + 2'h1;
      end else if (mode_i == 2'h0) begin
        ack_n_o <= port16_i ? ACK_PORT16 : ACK_PORT8;
        if (!rw_i && port16_i && !a[0] && len_i != LEN_BYTE) begin
          mem[a] <= wdata_i[15:8];
          mem[a + 8'h01] <= wdata_i[7:0];
        end else if (!rw_i) begin
          mem[a] <= (port16_i && a[0]) ? wdata_i[7:0] : wdata_i[15:8];
        end
      end else if (mode_i == 2'h1) begin
        fault_n_o <= 1'b0;
      end else if (mode_i == 2'h3) begin
        auto_vector_ack_n_n_o <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// ---- verification/tb.sv ----
// self-checking bench for the external bus master with its bus partner
// assumes the package constants and one 200 MHz clock
`timescale 1ns/1ps
`default_nettype none
`define CHECK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin fail_count++; \
  $display("mismatch %s expected %0h seen %0h", nm, e, g); end end
module tb;
  import ext_bus_pkg::*;
  typedef struct packed {
    logic wr; logic [ADDR_W-1:0] ad; logic [1:0] ln; logic [2:0] sp;
    logic p16; logic [OPND_W-1:0] d; logic [1:0] nb;
  } row_type;
  logic              clk_sys_i, reset_n_i, req_valid_i, req_write_i, req_iack_i, rsp_ready_i;
  logic              halt_n_i, ext_master_owns_i, bus_fault_n_i, auto_vector_ack_n_i;
  logic              req_ready_o, rsp_valid_o, rsp_fault_o, rsp_autovec_o, ctrl_oe_o, data_oe_o;
  logic              address_strobe_n_o, data_strobe_n_o, read_write_o, bus_fault_n_o;
  logic              bus_fault_oe_o, halted_o, irq_hold_o, p16, fault_n, as_q, ds_q;
  logic              exp_rw, rw_q, got_f, got_v, fault_seen;
  logic [1:0]        req_len_i, port_width_ack_n_i, transfer_length_code_o, mode, wait_n, exp_ln;
  logic [2:0]        req_space_i, space_code_o, exp_sp;
  logic [ADDR_W-1:0] req_addr_i, addr_o, addr_q;
  logic [DATA_W-1:0] data_i, data_o, part_data;
  logic [OPND_W-1:0] req_wdata_i, rsp_data_o, got_d;
  int                fail_count, comparisons, cyc, as_t, nbc;
  // write, address, length, space, 16-bit port, operand, bus cycles
  row_type rows [8] = '{
    '{1'b1, 24'h00_0010, LEN_LONG, SPC_USER_DATA, 1'b1, 32'h1122_3344, 2'h2},
    '{1'b0, 24'h00_0010, LEN_LONG, SPC_USER_PROG, 1'b1, 32'h1122_3344, 2'h2},
    '{1'b1, 24'h00_0021, LEN_WORD, SPC_SUPV_DATA, 1'b0, 32'h0000_aabb, 2'h2},
    '{1'b0, 24'h00_0021, LEN_WORD, SPC_SUPV_PROG, 1'b1, 32'h0000_aabb, 2'h2},
    '{1'b1, 24'h00_0030, LEN_THREE, SPC_USER_DATA, 1'b0, 32'h00cc_ddee, 2'h3},
    '{1'b0, 24'h00_0030, LEN_THREE, SPC_PROCESSOR, 1'b1, 32'h00cc_ddee, 2'h2},
    '{1'b1, 24'h00_0041, LEN_BYTE, SPC_USER_DATA, 1'b1, 32'h0000_005a, 2'h1},
    '{1'b0, 24'h00_0041, LEN_BYTE, SPC_USER_DATA, 1'b0, 32'h0000_005a, 2'h1}};
  // shared wires: whoever enables wins, fault line is wired-and
  assign data_i = data_oe_o ? data_o : part_data;
  assign bus_fault_n_i = fault_n & (bus_fault_oe_o ? bus_fault_n_o : 1'b1);
  ext_bus_master u_dut (.*);
  bus_partner_model u_partner (.clk_i(clk_sys_i), .as_n_i(address_strobe_n_o),
    .ds_n_i(data_strobe_n_o), .rw_i(read_write_o), .addr_i(addr_o),
    .len_i(transfer_length_code_o), .wdata_i(data_o), .port16_i(p16), .wait_i(wait_n),
    .mode_i(mode), .data_o(part_data), .ack_n_o(port_width_ack_n_i), .fault_n_o(fault_n),
    .auto_vector_ack_n_n_o(auto_vector_ack_n_i));
  initial begin
    clk_sys_i = 1'b0;
    forever #2.5 clk_sys_i = ~clk_sys_i;
  end
  // pin watcher: strobe spacing, codes and holding while the strobe is low
  always @(negedge clk_sys_i) begin
    cyc++;
    if (bus_fault_oe_o === 1'b1) fault_seen = 1'b1;
    if (!address_strobe_n_o && as_q) begin
      as_t = cyc;
      if (nbc == 0) `CHECK("length", exp_ln, transfer_length_code_o)
      nbc++;
      `CHECK("space", exp_sp, space_code_o)
      `CHECK("direction", exp_rw, read_write_o)
    end
    if (!data_strobe_n_o && ds_q) begin
      `CHECK("strobe gap", exp_rw ? 0 : 2, cyc - as_t)
      `CHECK("write drive", !exp_rw, data_oe_o)
    end
    if (!address_strobe_n_o && !as_q) `CHECK("hold", {addr_q, rw_q}, {addr_o, read_write_o})
    {as_q, ds_q, addr_q, rw_q} = {address_strobe_n_o, data_strobe_n_o, addr_o, read_write_o};
  end
  // offer one request and drop it once taken; entered at a falling edge
  task automatic send(input row_type r, input logic ik);
    int n;
    n = 0;
    // let one edge pass so a previous drop of valid is seen
    @(negedge clk_sys_i);
    {req_write_i, req_addr_i, req_len_i, req_space_i, req_wdata_i} = {r.wr, r.ad, r.ln, r.sp, r.d};
    {req_iack_i, req_valid_i} = {ik, 1'b1};
    while (req_ready_o !== 1'b1 && n < 500) begin
      n++;
      @(negedge clk_sys_i);
    end
    if (n == 500) begin
      fail_count++;
      final_report();
    end
    // expectations move only once the earlier transfer has left the bus
    {exp_rw, exp_sp, exp_ln, nbc, p16} = {!r.wr, r.sp, r.ln, 32'h0000_0000, r.p16};
    @(negedge clk_sys_i);
    req_valid_i = 1'b0;
  endtask
  // wait for a response, bounded, and take it
  task automatic take();
    int n;
    n = 0;
    @(negedge clk_sys_i);
    while (rsp_valid_o !== 1'b1 && n < 2000) begin
      n++;
      @(negedge clk_sys_i);
    end
    if (n == 2000) begin
      fail_count++;
      final_report();
    end
    {got_d, got_f, got_v} = {rsp_data_o, rsp_fault_o, rsp_autovec_o};
    rsp_ready_i = 1'b1;
    @(negedge clk_sys_i);
    rsp_ready_i = 1'b0;
  endtask
  // halt raised during a transfer: park, then resume or retry on release
  task automatic halt_case(input logic [1:0] md, input row_type r);
    int n;
    n = 0;
    mode = md;
    send(r, 1'b0);
    halt_n_i = 1'b0;
    while (halted_o !== 1'b1 && n < 300) begin
      n++;
      @(negedge clk_sys_i);
    end
    `CHECK("park", 4'b1101, {address_strobe_n_o, data_strobe_n_o, data_oe_o, irq_hold_o})
    `CHECK("park addr", r.ad, addr_o)
    {mode, halt_n_i} = 3'b001;
    take();
    `CHECK("resume", {r.wr ? 32'h0000_0000 : r.d, 1'b0}, {got_d, got_f})
  endtask
  task automatic final_report();
    $display("comparisons %0d fail_count %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  initial begin
    repeat (30000) @(posedge clk_sys_i);
    fail_count++;
    final_report();
  end
  initial begin
    {fail_count, comparisons, cyc, as_t, nbc, fault_seen, mode, wait_n} = 0;
    {req_valid_i, req_write_i, req_iack_i, rsp_ready_i, req_len_i, req_space_i} = 0;
    {req_addr_i, req_wdata_i, p16, halt_n_i, ext_master_owns_i, reset_n_i} = 4'b1110;
    repeat (3) @(negedge clk_sys_i);
    `CHECK("reset pins", 4'b1100, {address_strobe_n_o, data_strobe_n_o, data_oe_o, rsp_valid_o})
    reset_n_i = 1'b1;
    repeat (6) @(negedge clk_sys_i);
    `CHECK("owned", 2'b00, {ctrl_oe_o, req_ready_o})
    ext_master_owns_i = 1'b0;
    repeat (4) @(negedge clk_sys_i);
    for (int i = 0; i < 8; i++) begin
      wait_n = i[1:0];
      send(rows[i], 1'b0);
      take();
      `CHECK("data", rows[i].wr ? 32'h0000_0000 : rows[i].d, got_d)
      `CHECK("cycles", {rows[i].nb, 1'b0}, {nbc[1:0], got_f})
    end
    mode = 2'h1;
    send(rows[7], 1'b0);
    take();
    `CHECK("fault end", 2'b10, {got_f, got_v})
    mode = 2'h3;
    send(rows[7], 1'b1);
    take();
    `CHECK("monitor", 3'b101, {got_f, got_v, fault_seen})
    send(rows[5], 1'b1);
    take();
    `CHECK("vector", {32'h0000_0000, 2'b01}, {got_d, got_f, got_v})
    halt_case(2'h0, rows[0]);
    halt_case(2'h1, rows[1]);
    send(rows[7], 1'b0);
    send(rows[3], 1'b0);
    repeat (60) @(negedge clk_sys_i);
    `CHECK("buffer full", 2'b10, {rsp_valid_o, req_ready_o})
    take();
    `CHECK("first", rows[7].d, got_d)
    take();
    `CHECK("second", rows[3].d, got_d)
    // reset again in mid-run: pins quiet, then ready once ownership settles
    reset_n_i = 1'b0;
    repeat (3) @(negedge clk_sys_i);
    `CHECK("reset again", 5'b11001, {address_strobe_n_o, data_strobe_n_o, data_oe_o, rsp_valid_o, read_write_o})
    reset_n_i = 1'b1;
    repeat (6) @(negedge clk_sys_i);
    `CHECK("ready again", 2'b11, {ctrl_oe_o, req_ready_o})
    final_report();
  end
endmodule
`default_nettype wire
